// File: pkg/bmc_pkg.sv
// package for the baseband mode configuration register bank
`default_nettype none
package bmc_pkg;
  localparam logic [7:0] ADDR_RADIO_CONTROL  = 8'h03;
  localparam logic [7:0] ADDR_SPREAD_RATE    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_PIN_CFG    = 8'h05;
  localparam logic [7:0] RST_RADIO_CONTROL   = 8'h00;
  localparam logic [7:0] RST_SPREAD_RATE     = 8'h00;
  localparam logic [7:0] RST_IRQ_PIN_CFG     = 8'h01;
  localparam int         BIT_CODE_HALF       = 5;
  localparam int         BIT_AUTO_PA_DIS     = 3;
  localparam int         BIT_PA_EN           = 2;
  localparam int         BIT_CODE_WIDTH      = 2;
  localparam int         BIT_DATA_RATE       = 1;
  localparam int         BIT_SAMPLE_RATE     = 0;
  localparam logic [1:0] IRQ_OPEN_SOURCE     = 2'h3;
  localparam logic [1:0] IRQ_OPEN_DRAIN      = 2'h2;
  localparam logic [1:0] IRQ_CMOS            = 2'h1;
  localparam logic [1:0] IRQ_CMOS_INV        = 2'h0;
  localparam int         BIT_IRQ_SEL_LO      = 0;
  localparam logic       RST_IRQ_OUT         = 1'b0;
  localparam logic       RST_IRQ_OE_N        = 1'b0;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bmc_wr_t;

  typedef struct packed {
    logic       power_amplifier_on;
    logic       chips_32;
    logic       double_rate;
    logic       oversample_12x;
    logic       code_upper_half;
  } bmc_mode_t;
endpackage : bmc_pkg
`default_nettype wire

// File: src/bmc_regs.sv
// baseband mode configuration register bank with irq pin driver
`default_nettype none
module bmc_regs
(
  input  wire logic            clk_sys,
  input  wire logic            srst,
  input  wire bmc_pkg::bmc_wr_t wr,
  input  wire logic [7:0]      rd_addr,
  output var  logic [7:0]      rd_data,
  output var  logic            rd_hit,
  input  wire logic            baseband_pa_request,
  input  wire logic            irq_request,
  output var  logic            irq_out,
  output var  logic            irq_oe_n,
  output var  bmc_pkg::bmc_mode_t mode,
  output var  logic [31:0]     code_active,
  output var  logic            code_pair_mode,
  input  wire logic [63:0]     spreading_code
);

  localparam int NUM_REGS = 3;

  logic [7:0]         radio_control_reg;
  logic [7:0]         spreading_rate_select_reg;
  logic [7:0]         irq_pin_drive_config_reg;
  logic [7:0]         bank_reg [NUM_REGS];
  logic [2:0]         wr_sel;
  logic [2:0]         rd_sel;
  logic [7:0]         rd_data_next;
  logic               rd_hit_next;
  logic               irq_out_next;
  logic               irq_oe_n_next;
  bmc_pkg::bmc_mode_t mode_next;
  logic [31:0]        code_active_next;
  logic               code_pair_next;

  // one address decoder for writes and reads keeps the two maps identical
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] sel;
    sel    = 3'b000;
    sel[0] = (addr == bmc_pkg::ADDR_RADIO_CONTROL);
    sel[1] = (addr == bmc_pkg::ADDR_SPREAD_RATE);
    sel[2] = (addr == bmc_pkg::ADDR_IRQ_PIN_CFG);
    return sel;
  endfunction

  function automatic logic [7:0] reg_reset(input int idx);
    logic [7:0] val;
    case (idx)
      0:       val = bmc_pkg::RST_RADIO_CONTROL;
      1:       val = bmc_pkg::RST_SPREAD_RATE;
      2:       val = bmc_pkg::RST_IRQ_PIN_CFG;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // released modes let the pin float while no interrupt is pending
  function automatic logic irq_is_open(input logic [1:0] sel);
    return (sel == bmc_pkg::IRQ_OPEN_SOURCE) || (sel == bmc_pkg::IRQ_OPEN_DRAIN);
  endfunction

  function automatic logic irq_is_high(input logic [1:0] sel);
    return (sel == bmc_pkg::IRQ_OPEN_SOURCE) || (sel == bmc_pkg::IRQ_CMOS);
  endfunction

  assign wr_sel = wr.wr_en ? reg_sel(wr.addr) : 3'b000;
  assign rd_sel = reg_sel(rd_addr);

  // every written bit is stored, reserved ones too, so reads return what was written
  for (genvar i = 0; i < NUM_REGS; i++)
  begin : g_bank
    always_ff @(posedge clk_sys)
    begin
      if (srst)
        bank_reg[i] <= reg_reset(i);
      else if (wr_sel[i])
        bank_reg[i] <= wr.wdata;
    end
  end

  assign radio_control_reg         = bank_reg[0];
  assign spreading_rate_select_reg = bank_reg[1];
  assign irq_pin_drive_config_reg  = bank_reg[2];

  wire auto_dis    = radio_control_reg[bmc_pkg::BIT_AUTO_PA_DIS];
  wire pa_en_bit   = radio_control_reg[bmc_pkg::BIT_PA_EN];
  wire half_bit    = radio_control_reg[bmc_pkg::BIT_CODE_HALF];
  wire width_32    = spreading_rate_select_reg[bmc_pkg::BIT_CODE_WIDTH];
  wire rate_bit    = spreading_rate_select_reg[bmc_pkg::BIT_DATA_RATE];
  wire sample_bit  = spreading_rate_select_reg[bmc_pkg::BIT_SAMPLE_RATE];
  wire [1:0] irq_sel = irq_pin_drive_config_reg[bmc_pkg::BIT_IRQ_SEL_LO +: 2];

  // invalid combinations fall back to the applicable mode instead of trapping
  wire pa_on       = auto_dis ? pa_en_bit : baseband_pa_request;
  wire dbl_rate    = width_32 && rate_bit;
  wire over12      = width_32 && !rate_bit && sample_bit;
  wire upper_half  = width_32 && !rate_bit && half_bit;

  always_comb
  begin
    mode_next.power_amplifier_on = pa_on;
    mode_next.chips_32           = width_32;
    mode_next.double_rate        = dbl_rate;
    mode_next.oversample_12x     = over12;
    mode_next.code_upper_half    = upper_half;
  end

  // double rate hands both halves to the correlator; the select below is the first half
  assign code_pair_next   = dbl_rate;
  assign code_active_next = upper_half ? spreading_code[63:32] : spreading_code[31:0];

  // push pull modes keep the pin driven; open modes release it when idle
  assign irq_oe_n_next = irq_is_open(irq_sel) ? !irq_request : 1'b0;
  assign irq_out_next  = irq_is_high(irq_sel) ? irq_request : !irq_request;

  assign rd_hit_next  = |rd_sel;
  assign rd_data_next = rd_sel[0] ? radio_control_reg :
                        rd_sel[1] ? spreading_rate_select_reg :
                        rd_sel[2] ? irq_pin_drive_config_reg : 8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      rd_data <= rd_data_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rd_hit <= 1'b0;
    end
    else
    begin
      rd_hit <= rd_hit_next;
    end
  end

  // reset value matches the default push pull mode with no interrupt pending
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      irq_out <= bmc_pkg::RST_IRQ_OUT;
    end
    else
    begin
      irq_out <= irq_out_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      irq_oe_n <= bmc_pkg::RST_IRQ_OE_N;
    end
    else
    begin
      irq_oe_n <= irq_oe_n_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode <= '0;
    end
    else
    begin
      mode <= mode_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      code_active <= 32'h00000000;
    end
    else
    begin
      code_active <= code_active_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      code_pair_mode <= 1'b0;
    end
    else
    begin
      code_pair_mode <= code_pair_next;
    end
  end

endmodule // bmc_regs
`default_nettype wire

// File: testbench/bmc_host.sv
// host model writing and reading the mode registers
`default_nettype none
module bmc_host
(
  input  wire logic             clk_sys,
  output var  bmc_pkg::bmc_wr_t wr,
  output var  logic [7:0]       rd_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial wr = '0;
  initial rd_addr = 8'h00;
  task automatic put(input logic e, input logic [7:0] a, input logic [7:0] d, input logic [7:0] r);
    wr <= '{e, a, d & (a == 8'h03 ? 8'hFC : a == 8'h04 ? 8'h07 : a == 8'h05 ? 8'h03 : 8'hFF)};
    rd_addr <= r;
    @(posedge clk_sys);
  endtask
endmodule // bmc_host
`default_nettype wire

// File: testbench/bmc_regs_assertions.sv
// port assertions for the mode register bank
`default_nettype none
module bmc_regs_assertions
(
  input wire logic               clk_sys,
  input wire logic               srst,
  input wire bmc_pkg::bmc_wr_t   wr,
  input wire logic [7:0]         rd_addr,
  input wire logic [7:0]         rd_data,
  input wire logic               irq_request,
  input wire logic               irq_oe_n,
  input wire bmc_pkg::bmc_mode_t mode,
  input wire logic [31:0]        code_active,
  input wire logic               code_pair_mode,
  input wire logic [63:0]        spreading_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence wr_at(a); wr.wr_en && wr.addr == a ##1 !(wr.wr_en && wr.addr == a); endsequence
  sequence rd_after(a); wr.wr_en && wr.addr == a ##1 rd_addr == a && !(wr.wr_en && wr.addr == a); endsequence
  chk_rate_needs_chips: assert property (mode.double_rate |-> mode.chips_32) else $error("rate");
  chk_fast_sample_mode: assert property (mode.oversample_12x |-> mode.chips_32 && !mode.double_rate)
    else $error("12x");
  chk_pair_follows_rate: assert property (wr_at(8'h04) |-> ##1
    code_pair_mode == ($past(wr.wdata[2], 2) & $past(wr.wdata[1], 2))) else $error("pair");
  chk_code_half_pick: assert property (!$past(srst) |-> code_active == (mode.code_upper_half ?
    $past(spreading_code[63:32]) : $past(spreading_code[31:0]))) else $error("half");
  chk_irq_drive_busy: assert property ($past(irq_request) && !$past(srst) |-> !irq_oe_n) else $error("irq");
  chk_rate_decode: assert property (wr_at(8'h04) |-> ##1 mode.chips_32 == $past(wr.wdata[2], 2) &&
    mode.double_rate == ($past(wr.wdata[2], 2) & $past(wr.wdata[1], 2))) else $error("width");
  chk_sample_decode: assert property (wr_at(8'h04) |-> ##1
    mode.oversample_12x == ($past(wr.wdata[2:0], 2) == 3'h5)) else $error("sample");
  chk_reg_readback: assert property (rd_after(8'h03) |=> rd_data == $past(wr.wdata, 2)) else $error("read");
endmodule // bmc_regs_assertions
bind bmc_regs bmc_regs_assertions u_bmc_regs_assertions (.clk_sys, .srst, .wr, .rd_addr, .rd_data,
  .irq_request, .irq_oe_n, .mode, .code_active, .code_pair_mode, .spreading_code);
`default_nettype wire

// File: testbench/baseband_mode_config_bench.sv
// self-checking bench for the mode register bank
`default_nettype none
module baseband_mode_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, srst = 1'b1, pa = 1'b0, irq_request = 1'b0, rd_hit, irq_out, irq_oe_n, pair;
  logic [63:0] code = '0;
  logic [7:0] rd_addr, rd_data, c, r;
  logic [31:0] code_active;
  bmc_pkg::bmc_wr_t wr;
  bmc_pkg::bmc_mode_t mode, em;
  int num_errors = 0, total_checks = 0, cyc = 0, seed = 32'hfce5f626;
  always #50 clk_sys = ~clk_sys;
  bmc_host u_bmc_host (.clk_sys(clk_sys), .wr(wr), .rd_addr(rd_addr));
  bmc_regs u_bmc_regs (.clk_sys(clk_sys), .srst(srst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_hit(rd_hit), .baseband_pa_request(pa), .irq_request(irq_request), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n), .mode(mode), .code_active(code_active), .code_pair_mode(pair), .spreading_code(code));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // invalid rate codes degrade instead of being refused
  function automatic bmc_pkg::bmc_mode_t exp_mode(logic [7:0] c, logic [7:0] r, logic p);
    return '{c[3] ? c[2] : p, r[2], r[2] & r[1], r[2] & !r[1] & r[0], c[5] & r[2] & !r[1]};
  endfunction
  // released pin keeps following the request; only the enable says it floats
  function automatic logic [1:0] exp_irq(logic [1:0] sel, logic req);
    return {sel[1] & !req, sel[0] ~^ req};
  endfunction
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic do_reset();
    srst <= 1'b1;
    pa <= 1'b0;
    code <= '0;
    irq_request <= 1'b0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 3; a < 7; a++)
    begin
      u_bmc_host.put(1'b0, 8'h00, 8'h00, 8'(a));
      @(posedge clk_sys);
      chk({rd_hit, rd_data}, {a != 6, a == 5 ? 8'h01 : 8'h00});
    end
    chk({irq_oe_n, irq_out, pair, mode}, 32'h0);
    chk(code_active, 32'h0);
    $display("reset test done");
  endtask
  initial
  begin
    do_reset();
    for (int i = 0; i < 40; i++)
    begin
      c = i == 0 ? 8'h24 : i == 1 ? 8'h2C : 8'($random(seed));
      r = i < 2 ? 8'h04 : 8'($random(seed)) & 8'h07;
      if (!r[2])
        r = 8'h00;
      else if (r[1])
        r[0] = 1'b0;
      code <= {$random(seed), $random(seed)};
      pa <= c[0];
      u_bmc_host.put(1'b1, 8'h03, c, 8'h00);
      u_bmc_host.put(1'b1, 8'h04, r, 8'h03);
      u_bmc_host.put(1'b0, 8'h00, 8'h00, 8'h04);
      chk(rd_data, c & 8'hFC);
      @(posedge clk_sys);
      em = exp_mode(c, r, c[0]);
      chk({pair, mode}, {em.double_rate, em});
      chk(code_active, em.code_upper_half ? code[63:32] : code[31:0]);
      chk(rd_data, r & 8'h07);
    end
    $display("mode test done");
    do_reset();
    for (int m = 0; m < 8; m++)
    begin
      irq_request <= m[0];
      u_bmc_host.put(1'b1, 8'h05, 8'(m >> 1), 8'h05);
      u_bmc_host.put(1'b0, 8'h00, 8'h00, 8'h05);
      @(posedge clk_sys);
      chk({irq_oe_n, irq_out}, exp_irq(2'(m >> 1), m[0]));
    end
    $display("irq test done");
    results();
  end
endmodule // baseband_mode_config_bench
`default_nettype wire
